// ### rtl/rbag_pkg.sv
// Package for the register-bit address generator.
// Assumes one clock and a synchronous active-high reset.
package rbag_pkg;

   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam int CTRL_W = 10;
   localparam int CTRL_COMPAT_BIT = 0;
   localparam int CTRL_CIRC_LSB = 1;
   localparam int CTRL_CCIRC_BIT = 9;
   localparam logic [9:0] CTRL_RST = 10'h000;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   localparam logic [15:0] STEP_TWO = 16'h0002;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [2:0] K3_ZERO = 3'h0;

   typedef enum logic [4:0] {
      M_AR_PLAIN = 5'h00, M_AR_POSTINC = 5'h01,
      M_AR_POSTDEC = 5'h02, M_AR_PREINC = 5'h03,
      M_AR_PREDEC = 5'h04, M_AR_ADD_T = 5'h05,
      M_AR_SUB_T = 5'h06, M_AR_IDX_T = 5'h07,
      M_AR_BR_ADD = 5'h08, M_AR_BR_SUB = 5'h09,
      M_AR_ADD_T1 = 5'h0a, M_AR_SUB_T1 = 5'h0b,
      M_AR_IDX_T1 = 5'h0c, M_AR_K16 = 5'h0d,
      M_AR_PRE_K16 = 5'h0e, M_AR_K3 = 5'h0f,
      M_CDP_PLAIN = 5'h10, M_CDP_POSTINC = 5'h11,
      M_CDP_POSTDEC = 5'h12, M_CDP_K16 = 5'h13,
      M_CDP_PRE_K16 = 5'h14
   } rbag_mode_e;

   typedef enum logic [2:0] {
      I_TEST = 3'h0, I_SET = 3'h1, I_CLR = 3'h2,
      I_CPL = 3'h3, I_TEST2 = 3'h4, I_OTHER = 3'h5
   } rbag_instr_e;

   typedef enum logic [1:0] {
      T_ACC = 2'h0, T_AUX = 2'h1, T_TEMP = 2'h2, T_OTHER = 2'h3
   } rbag_target_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_CALC = 2'b01, S_DONE = 2'b11
   } rbag_state_e;

   typedef struct packed {
      rbag_mode_e mode;
      logic [2:0] ptrSel;
      rbag_instr_e instr;
      rbag_target_e target;
      logic [15:0] longConst;
      logic [2:0] shortConst;
   } rbag_req_s;

   typedef struct packed {
      logic [15:0] auxPtr;
      logic [15:0] coeffPtr;
      logic [15:0] tempZero;
      logic [15:0] tempOne;
      logic [15:0] auxZero;
      logic [15:0] bufStart;
      logic [15:0] coeffStart;
      logic [39:0] srcVal;
   } rbag_opnd_s;

   typedef struct packed {
      logic we;
      logic isCoeff;
      logic [2:0] sel;
      logic [15:0] data;
   } rbag_wb_s;

endpackage

// ### rtl/rbag_rev_add.sv
// Reverse-carry adder and subtractor for 16-bit pointers.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module rbag_rev_add
   import rbag_pkg::*;
(
   input wire logic [15:0] base,
   input wire logic [15:0] offset,
   input wire logic subtract,
   output logic [15:0] result
);

   logic [15:0] baseRev;
   logic [15:0] offRev;
   logic [15:0] sumRev;

   // Mirror operands so carries run from msb toward lsb
   for (genvar i = 0; i < 16; i++) begin : g_rev
      assign baseRev[i] = base[15 - i];
      assign offRev[i] = offset[15 - i];
      assign result[i] = sumRev[15 - i];
   end

   assign sumRev = subtract ? baseRev - offRev : baseRev + offRev;

endmodule // rbag_rev_add
`default_nettype wire

// ### rtl/rbag_top.sv
// Register-bit address generator with APB control and status.
// Assumes decoder holds req and opnd while reqValid and reqReady.
//
// Contract
// - Bit-reversed add: use pointer, reverse-carry add
// - Bit-reversed subtract: use pointer, reverse-carry subtract
// - Circular bit-reversed: add start, keep pointer
// - Compat bit picks pointer zero, else temp
// - Post-add temp one after addressing
// - Post-subtract temp one after addressing
// - Address pointer plus temp one, unchanged
// - Address pointer plus signed constant, unchanged
// - Long-constant instructions refuse parallel issue
// - Pre-add constant, then address with result
// - Short constant one to seven, pointer unchanged
// - Coefficient pointer plain, plus start, unchanged
// - Coefficient post-increment by one or two
// - Coefficient post-decrement by one or two
// - Coefficient plus signed constant, unchanged
// - Coefficient pre-add constant, then address
// - Two-bit test loads both test flags
// - Only bit ops on acc, aux, temp
`timescale 1ns/1ps
`default_nettype none
module rbag_top
   import rbag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reqValid,
   input wire rbag_req_s req,
   input wire rbag_opnd_s opnd,
   output logic reqReady,
   output logic done,
   output logic refused,
   output logic parallelBlock,
   output logic [15:0] bitAddr,
   output rbag_wb_s ptrWb,
   output logic flagWe,
   output logic testFlagOne,
   output logic testFlagTwo
);

   rbag_state_e state;
   rbag_state_e next_state;
   rbag_req_s reqHeld;
   rbag_opnd_s opndHeld;
   logic [CTRL_W-1:0] ctrl;

   // Request handshake and sequencing
   wire accept = reqValid & reqReady;

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: begin
            if (accept) begin
               next_state = S_CALC;
            end
         end
         S_CALC: begin
            next_state = S_DONE;
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= S_IDLE;
         reqReady <= 1'b1;
      end else begin
         state <= next_state;
         reqReady <= (next_state == S_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reqHeld <= '0;
         opndHeld <= '0;
      end else if (accept) begin
         reqHeld <= req;
         opndHeld <= opnd;
      end
   end

   wire inCalc = (state == S_CALC);
   rbag_mode_e m;
   assign m = reqHeld.mode;

   // Operand selection
   wire isCoeff = m inside {M_CDP_PLAIN, M_CDP_POSTINC,
      M_CDP_POSTDEC, M_CDP_K16, M_CDP_PRE_K16};
   wire legalMode = (m <= M_CDP_PRE_K16);
   wire compat = ctrl[CTRL_COMPAT_BIT];
   wire [7:0] auxCirc = ctrl[CTRL_CIRC_LSB +: 8];
   wire circ = isCoeff ? ctrl[CTRL_CCIRC_BIT]
      : auxCirc[reqHeld.ptrSel];
   wire twoBit = (reqHeld.instr == I_TEST2);
   wire [15:0] base = isCoeff ? opndHeld.coeffPtr
      : opndHeld.auxPtr;
   wire [15:0] bsa = isCoeff ? opndHeld.coeffStart
      : opndHeld.bufStart;
   wire [15:0] off0 = compat ? opndHeld.auxZero
      : opndHeld.tempZero;
   wire [15:0] t1 = opndHeld.tempOne;
   wire [15:0] k16 = reqHeld.longConst;
   wire [15:0] k3 = {13'h0000, reqHeld.shortConst};
   wire [15:0] step = twoBit ? STEP_TWO : STEP_ONE;

   // Mode classes
   wire modPost = m inside {M_AR_POSTINC, M_AR_POSTDEC,
      M_AR_ADD_T, M_AR_SUB_T, M_AR_BR_ADD, M_AR_BR_SUB,
      M_AR_ADD_T1, M_AR_SUB_T1, M_CDP_POSTINC, M_CDP_POSTDEC};
   wire modPre = m inside {M_AR_PREINC, M_AR_PREDEC,
      M_AR_PRE_K16, M_CDP_PRE_K16};
   wire isRev = m inside {M_AR_BR_ADD, M_AR_BR_SUB};
   wire hasExt = m inside {M_AR_K16, M_AR_PRE_K16,
      M_CDP_K16, M_CDP_PRE_K16};

   // Refusal of operands outside the supported set
   wire badTarget = (reqHeld.target == T_OTHER)
      | (reqHeld.instr == I_OTHER);
   wire badK3 = (m == M_AR_K3)
      & (reqHeld.shortConst == K3_ZERO);
   wire bad = badTarget | badK3 | ~legalMode;

   // Bit-reversed pointer update
   wire [15:0] revOut;

   rbag_rev_add u_rev (
      .base(base),
      .offset(off0),
      .subtract(m == M_AR_BR_SUB),
      .result(revOut)
   );

   // New pointer value for every modifying mode
   wire incMode = m inside {M_AR_POSTINC, M_AR_PREINC,
      M_CDP_POSTINC};
   wire decMode = m inside {M_AR_POSTDEC, M_AR_PREDEC,
      M_CDP_POSTDEC};
   wire k16Pre = m inside {M_AR_PRE_K16, M_CDP_PRE_K16};

   wire [15:0] newPtr =
      incMode ? base + step :
      decMode ? base - step :
      (m == M_AR_ADD_T) ? base + off0 :
      (m == M_AR_SUB_T) ? base - off0 :
      isRev ? revOut :
      (m == M_AR_ADD_T1) ? base + t1 :
      (m == M_AR_SUB_T1) ? base - t1 :
      k16Pre ? base + k16 :
      base;

   // Offset added to the address only
   wire [15:0] index =
      (m == M_AR_IDX_T) ? off0 :
      (m == M_AR_IDX_T1) ? t1 :
      (m == M_AR_K16) ? k16 :
      (m == M_CDP_K16) ? k16 :
      (m == M_AR_K3) ? k3 :
      ZERO16;

   // Pre modes address with the updated pointer
   wire [15:0] addrPtr = modPre ? newPtr : base;
   wire [15:0] circAdd = circ ? bsa : ZERO16;
   wire [15:0] nextAddr = addrPtr + index + circAdd;

   // Circular bit-reversed pointers are left alone
   wire wbEnable = (modPost | modPre)
      & ~(isRev & circ) & ~bad;

   // Source bits for the two-bit test
   wire [39:0] srcShift = opndHeld.srcVal >> nextAddr;
   wire flagA = srcShift[0];
   wire flagB = srcShift[1];

   // Result registers
   always_ff @(posedge clk) begin
      if (rst) begin
         done <= 1'b0;
         refused <= 1'b0;
         parallelBlock <= 1'b0;
         bitAddr <= ZERO16;
         ptrWb <= '0;
         flagWe <= 1'b0;
         testFlagOne <= 1'b0;
         testFlagTwo <= 1'b0;
      end else if (inCalc) begin
         done <= 1'b1;
         refused <= bad;
         parallelBlock <= hasExt;
         bitAddr <= nextAddr;
         ptrWb.we <= wbEnable;
         ptrWb.isCoeff <= isCoeff;
         ptrWb.sel <= reqHeld.ptrSel;
         ptrWb.data <= newPtr;
         flagWe <= twoBit & ~bad;
         testFlagOne <= twoBit & ~bad ? flagA : testFlagOne;
         testFlagTwo <= twoBit & ~bad ? flagB : testFlagTwo;
      end else begin
         done <= 1'b0;
         ptrWb.we <= 1'b0;
         flagWe <= 1'b0;
      end
   end

   // APB slave, no wait states
   wire apbSetup = psel & ~penable;
   wire apbTake = psel & penable & pready;
   wire hitCtrl = (paddr == CTRL_OFS);
   wire hitStat = (paddr == STAT_OFS);
   wire [31:0] statWord = {13'h0000, refused, testFlagTwo,
      testFlagOne, bitAddr};
   wire [31:0] ctrlWord = {22'h000000, ctrl};
   wire [31:0] readWord = hitCtrl ? ctrlWord
      : hitStat ? statWord : 32'h00000000;

   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= apbSetup;
         if (apbSetup) begin
            prdata <= readWord;
            pslverr <= ~(hitCtrl | hitStat);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RST;
      end else if (apbTake & pwrite & hitCtrl) begin
         ctrl <= pwdata[CTRL_W-1:0];
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_br_circ_hold: assert property (
      inCalc && isRev && circ |=> !ptrWb.we)
      else $error("circular bit-reversed pointer was written");

   chk_post_addr_use: assert property (
      inCalc && modPost && !bad |=>
      bitAddr == $past(base) + $past(circAdd)
      && ptrWb.we == !$past(isRev && circ))
      else $error("post-modify address not from old pointer");

   chk_pre_addr_use: assert property (
      inCalc && modPre && !bad |=>
      ptrWb.we && bitAddr == ptrWb.data + $past(circAdd))
      else $error("pre-modify address not from new pointer");

   chk_t1_post_add: assert property (
      inCalc && m == M_AR_ADD_T1 && !bad |=>
      ptrWb.data == $past(base) + $past(t1))
      else $error("post add of temp one wrong");

   chk_k3_zero_refuse: assert property (
      inCalc && badK3 |=> refused && !ptrWb.we && !flagWe)
      else $error("zero short constant not refused");

   chk_two_bit_flags: assert property (
      inCalc && twoBit && !bad |=> flagWe
      && testFlagOne == $past(flagA)
      && testFlagTwo == $past(flagB))
      else $error("test flags not loaded from source bits");

   chk_accept_done: assert property (
      accept |-> !done ##1 !done ##1 done ##1 !done)
      else $error("done not one pulse two cycles after accept");

   chk_coeff_step_two: assert property (
      inCalc && m == M_CDP_POSTINC && twoBit && !bad |=>
      ptrWb.data == $past(base) + 16'h0002)
      else $error("coefficient step not two on two-bit test");

   chk_ext_no_par: assert property (
      inCalc && hasExt |=> parallelBlock && done)
      else $error("extension instruction allowed in parallel");

   chk_bad_target: assert property (
      inCalc && badTarget |=> refused && !flagWe && !ptrWb.we)
      else $error("unsupported target or instruction accepted");

endmodule // rbag_top
`default_nettype wire

// ### sim/rbag_dec_model.sv
// Decoder-side model: presents one request and holds it until taken.
// Assumes the bench pulses go for one cycle while no request is pending.
`timescale 1ns/1ps
`default_nettype none
module rbag_dec_model
   import rbag_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire rbag_req_s reqIn,
   input wire rbag_opnd_s opndIn,
   input wire logic reqReady,
   output logic reqValid,
   output rbag_req_s req,
   output rbag_opnd_s opnd
);
   initial begin
      reqValid = 1'b0;
      req = '0;
      opnd = '0;
   end
   // Released lines show the inverse of the last value
   always @(posedge clk) begin
      if (rst) begin
         reqValid <= 1'b0;
      end else if (go) begin
         reqValid <= 1'b1;
         req <= reqIn;
         opnd <= opndIn;
      end else if (reqValid && reqReady) begin
         reqValid <= 1'b0;
         req <= ~req;
         opnd <= ~opnd;
      end
   end
endmodule // rbag_dec_model
`default_nettype wire

// ### sim/rbag_top_test.sv
// Self-checking bench for the register-bit address generator.
// Assumes the package, the design and the decoder model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rbag_top_test
   import rbag_pkg::*;
;
   logic clk, rst, psel, penable, pwrite, go, reqValid, reqReady, done;
   logic pready, pslverr, refused, parBlk, flagWe, tf1, tf2, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] bitAddr;
   rbag_wb_s ptrWb;
   rbag_req_s reqIn, req;
   rbag_opnd_s opIn, opnd;
   rbag_target_e tgt;
   logic [2:0] sel;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   rbag_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reqValid(reqValid), .req(req),
      .opnd(opnd), .reqReady(reqReady), .done(done), .refused(refused),
      .parallelBlock(parBlk), .bitAddr(bitAddr), .ptrWb(ptrWb),
      .flagWe(flagWe), .testFlagOne(tf1), .testFlagTwo(tf2));

   rbag_dec_model model (.clk(clk), .rst(rst), .go(go), .reqIn(reqIn),
      .opndIn(opIn), .reqReady(reqReady), .reqValid(reqValid), .req(req),
      .opnd(opnd));

   task automatic chk(input string nm, input logic [39:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic op(input rbag_mode_e m, input rbag_instr_e in,
      input logic [15:0] k16, input logic [2:0] k3,
      input logic [15:0] ea, ed, input logic er);
      logic [15:0] old;
      logic wantPar;
      old = (m >= M_CDP_PLAIN) ? opIn.coeffPtr : opIn.auxPtr;
      wantPar = m inside {M_AR_K16, M_AR_PRE_K16, M_CDP_K16, M_CDP_PRE_K16};
      @(posedge clk);
      reqIn <= '{m, sel, in, tgt, k16, k3};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(negedge clk); while (done !== 1'b1);
      chk("refused", refused, er);
      chk("wbData", ptrWb.we === 1'b1 ? ptrWb.data : old, ed);
      chk("flagWe", flagWe, !er && in == I_TEST2);
      chk("wbSel", ptrWb.sel, sel);
      chk("busy", reqReady, 1'b0);
      if (!er) begin
         chk("bitAddr", bitAddr, ea);
         chk("wbCoeff", ptrWb.isCoeff, m >= M_CDP_PLAIN);
         chk("parBlock", parBlk, wantPar);
         if (in == I_TEST2) begin
            chk("flagOne", tf1, opIn.srcVal[ea]);
            chk("flagTwo", tf2, opIn.srcVal[ea + 16'h1]);
         end
      end
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      go = 1'b0;
      reqIn = '0;
      tgt = T_ACC;
      sel = 3'h0;
      opIn = '{16'h1e, 16'h10, 16'h5, 16'h3, 16'h2, 16'h100, 16'h200,
         40'h0040020000};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk("readyIdle", reqReady, 1'b1);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrlReset", rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", rerr, 1'b1);
      op(M_AR_ADD_T1, I_SET, 16'h0, 3'h0, 16'h1e, 16'h21, 1'b0);
      op(M_AR_SUB_T1, I_TEST2, 16'h0, 3'h0, 16'h1e, 16'h1b, 1'b0);
      op(M_AR_IDX_T1, I_CLR, 16'h0, 3'h0, 16'h21, 16'h1e, 1'b0);
      op(M_AR_K16, I_CPL, 16'hfffe, 3'h0, 16'h1c, 16'h1e, 1'b0);
      op(M_AR_PRE_K16, I_SET, 16'h5, 3'h0, 16'h23, 16'h23, 1'b0);
      op(M_AR_K3, I_TEST, 16'h0, 3'h7, 16'h25, 16'h1e, 1'b0);
      op(M_AR_K3, I_SET, 16'h0, 3'h0, 16'h0, 16'h1e, 1'b1);
      op(M_AR_BR_ADD, I_SET, 16'h0, 3'h0, 16'h1e, 16'h18, 1'b0);
      op(M_AR_BR_SUB, I_SET, 16'h0, 3'h0, 16'h1e, 16'h1b, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrlBack", rd, 32'h1);
      op(M_AR_BR_SUB, I_SET, 16'h0, 3'h0, 16'h1e, 16'h1c, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h203);
      op(M_AR_BR_ADD, I_SET, 16'h0, 3'h0, 16'h11e, 16'h1e, 1'b0);
      op(M_AR_IDX_T1, I_SET, 16'h0, 3'h0, 16'h121, 16'h1e, 1'b0);
      op(M_CDP_PLAIN, I_SET, 16'h0, 3'h0, 16'h210, 16'h10, 1'b0);
      sel = 3'h1;
      op(M_AR_IDX_T1, I_SET, 16'h0, 3'h0, 16'h21, 16'h1e, 1'b0);
      sel = 3'h0;
      apb(1'b1, CTRL_OFS, 32'h0);
      op(M_AR_PLAIN, I_TEST, 16'h0, 3'h0, 16'h1e, 16'h1e, 1'b0);
      op(M_AR_POSTINC, I_SET, 16'h0, 3'h0, 16'h1e, 16'h1f, 1'b0);
      op(M_AR_PREINC, I_TEST2, 16'h0, 3'h0, 16'h20, 16'h20, 1'b0);
      op(M_AR_PREDEC, I_SET, 16'h0, 3'h0, 16'h1d, 16'h1d, 1'b0);
      op(M_AR_POSTDEC, I_TEST2, 16'h0, 3'h0, 16'h1e, 16'h1c, 1'b0);
      op(M_AR_ADD_T, I_SET, 16'h0, 3'h0, 16'h1e, 16'h23, 1'b0);
      op(M_AR_SUB_T, I_CLR, 16'h0, 3'h0, 16'h1e, 16'h19, 1'b0);
      op(M_AR_IDX_T, I_CPL, 16'h0, 3'h0, 16'h23, 16'h1e, 1'b0);
      op(rbag_mode_e'(5'h15), I_SET, 16'h0, 3'h0, 16'h0, 16'h10,
         1'b1);
      op(M_CDP_PLAIN, I_SET, 16'h0, 3'h0, 16'h10, 16'h10, 1'b0);
      op(M_CDP_POSTINC, I_SET, 16'h0, 3'h0, 16'h10, 16'h11, 1'b0);
      op(M_CDP_POSTINC, I_TEST2, 16'h0, 3'h0, 16'h10, 16'h12, 1'b0);
      op(M_CDP_POSTDEC, I_SET, 16'h0, 3'h0, 16'h10, 16'hf, 1'b0);
      op(M_CDP_POSTDEC, I_TEST2, 16'h0, 3'h0, 16'h10, 16'he, 1'b0);
      op(M_CDP_K16, I_SET, 16'h5, 3'h0, 16'h15, 16'h10, 1'b0);
      op(M_CDP_PRE_K16, I_SET, 16'h5, 3'h0, 16'h15, 16'h15, 1'b0);
      tgt = T_OTHER;
      op(M_AR_ADD_T1, I_SET, 16'h0, 3'h0, 16'h0, 16'h1e, 1'b1);
      tgt = T_ACC;
      op(M_AR_ADD_T1, I_OTHER, 16'h0, 3'h0, 16'h0, 16'h1e, 1'b1);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("statRefused", rd[18], 1'b1);
      chk("statFlags", rd[17:16], 2'b10);
      wrap_up();
   end
endmodule // rbag_top_test
`default_nettype wire
